// [src/t1gc_defines.vh]
// Register map, field positions, reset values and timing constants
`ifndef T1GC_DEFINES_VH
`define T1GC_DEFINES_VH

// ****************************************
// Register indices (byte address = 4 x index)
// ****************************************
`define T1GC_IDX_CHIP_IDENTITY    12'h001
`define T1GC_IDX_SOFT_RESET       12'h004
`define T1GC_IDX_GP_PIN_CONTROL   12'h006
`define T1GC_IDX_TIMER_IRQ_EN     12'h00a
`define T1GC_IDX_TIMER_IRQ_FLAG   12'h00b
`define T1GC_IDX_COUNTER_SELECT   12'h00e
`define T1GC_IDX_COUNTER_DATA     12'h00f
`define T1GC_IDX_SYS_MUX_CONFIG   12'h010
`define T1GC_IDX_LINE_STANDARD    12'h020
`define T1GC_IDX_DEJITTER_CONFIG  12'h021
`define T1GC_IDX_TX_PATH_CFG_A    12'h022
`define T1GC_IDX_TX_PATH_CFG_B    12'h023
`define T1GC_IDX_JITTER_STATUS    12'h038

// ****************************************
// Field positions
// ****************************************
`define T1GC_GP_LEVEL_BIT         2
`define T1GC_GP_DIR_BIT           0
`define T1GC_RX_MUX_BIT           3
`define T1GC_TX_MUX_BIT           0
`define T1GC_DJ_PEAK_BIT          5
`define T1GC_DJ_WIDEN_BIT         4
`define T1GC_DJ_ENABLE_BIT        3
`define T1GC_DJ_DEPTH_HI          2
`define T1GC_DJ_DEPTH_LO          1
`define T1GC_DJ_BW_BIT            0
`define T1GC_TX_OFF_BIT           4
`define T1GC_TX_CODE_BIT          0
`define T1GC_TX_FAULT_MON_BIT     5
`define T1GC_TX_HZ_BIT            4
`define T1GC_TX_SHAPE_HI          3
`define T1GC_LS_SELECT_BIT        0

// ****************************************
// Write masks and reset values
// ****************************************
`define T1GC_MASK_GP_PIN          8'h05
`define T1GC_MASK_BIT0            8'h01
`define T1GC_MASK_SELECT          8'h0f
`define T1GC_MASK_SYS_MUX         8'h09
`define T1GC_MASK_DEJITTER        8'h3f
`define T1GC_MASK_TX_CFG_A        8'h11
`define T1GC_MASK_TX_CFG_B        8'h3f
`define T1GC_RST_GP_PIN           8'h01
`define T1GC_RST_TX_CFG_B         8'h10
`define T1GC_RST_ZERO             8'h00
`define T1GC_PART_CODE            4'ha
`define T1GC_REV_CODE             4'h3
`define T1GC_LAST_COUNTER_SEL     4'hb

// ****************************************
// Timing and depth codes
// ****************************************
`define T1GC_SECOND_NS            1000000000
`define T1GC_CLK_PERIOD_NS        10
`define T1GC_DEPTH_128            2'b00
`define T1GC_DEPTH_64             2'b01
`define T1GC_MARGIN_128           7'h04
`define T1GC_MARGIN_64            7'h03
`define T1GC_MARGIN_32            7'h02
`define T1GC_SIZE_128             7'h7f
`define T1GC_SIZE_64              7'h40
`define T1GC_SIZE_32              7'h20

`endif

// [src/t1gc_counter_window.v]
// Counter byte window: selected counter byte held in a register
`timescale 1ns/100ps
`include "t1gc_defines.vh"

module t1gc_counter_window (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  input  wire        soft_clear,
  // Counter bytes, packed 12 x 8 bits, code 0 in low byte
  input  wire [95:0] counter_bytes,
  // Selection and result
  input  wire [3:0]  select,
  output reg  [7:0]  counter_read_byte
);

  // ****************************************
  // Registered read of selected byte
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_read_byte <= `T1GC_RST_ZERO;
    end else if (soft_clear) begin
      counter_read_byte <= `T1GC_RST_ZERO;
    end else if (select <= `T1GC_LAST_COUNTER_SEL) begin
      counter_read_byte <= counter_bytes[select*8 +: 8];
    end else begin
      counter_read_byte <= `T1GC_RST_ZERO;
    end
  end

endmodule

// [src/t1gc_regs.v]
// T1/J1 global control and status register bank with APB slave
//
// What this block does
// - Fixed read-only identity byte: part, revision
// - Any write to reset register resets
// - Soft reset restores defaults except line standard
// - Output pin: level bit read/write, drives pin
// - Input pin: level bit reads sampled pin
// - Direction bit: 0 output, 1 input; resets 1
// - One-second timer sets flag; write 1 clears
// - Interrupt low while flag and enable set
// - Four-bit select picks counter byte 0-0b
// - Counter data register reads selected byte
// - Independent rx and tx muxed mode bits
// - Status tracks pointer distance when not peak
// - Peak mode keeps the larger distance
// - Widen bit drops attenuation near FIFO limits
// - Enable bit turns attenuator on
// - Depth code: 128, 64, 32 bits
// - Bandwidth bit: 5 Hz or 1.26 Hz
// - Power-off bit kills tx path, driver Hi-Z
// - Line code bit: B8ZS at 0, AMI at 1
// - Tristate bit floats driver only; resets 1
// - Interrupt and attenuator enable act only in T1/J1 mode
//
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
`include "t1gc_defines.vh"

module t1gc_regs #(
  parameter        SECOND_CYCLES = `T1GC_SECOND_NS / `T1GC_CLK_PERIOD_NS,
  parameter [3:0]  PART_CODE     = `T1GC_PART_CODE, // Arbitrary value
  parameter [3:0]  REV_CODE      = `T1GC_REV_CODE   // Arbitrary value
) (
  // APB
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [13:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // General-purpose pin
  input  wire        gp_pin_in,
  output reg         gp_pin_out,
  output reg         gp_pin_oe,
  // Interrupt
  output reg         int_n,
  // Transmit elastic FIFO pointer distance
  input  wire [6:0]  tx_fifo_distance,
  // Counter bytes, 12 x 8 bits
  input  wire [95:0] counter_bytes,
  // Control outputs
  output reg         soft_reset_pulse,
  output reg         t1_mode_active,
  output reg         rx_system_side_muxed,
  output reg         tx_system_side_muxed,
  output reg         tx_dejitter_enable,
  output reg         tx_dejitter_bandwidth,
  output reg  [1:0]  tx_dejitter_depth,
  output reg         tx_dejitter_bypass,
  output reg         tx_path_power_off,
  output reg         tx_line_code_select,
  output reg         tx_driver_hiz,
  output reg         driver_fault_monitor_en,
  output reg  [3:0]  tx_pulse_shape
);

  // ****************************************
  // Declarations
  // ****************************************
  localparam [2:0] ST_IDLE   = 3'b001;
  localparam [2:0] ST_ACCESS = 3'b010;
  localparam [2:0] ST_DONE   = 3'b100;

  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [7:0]  gp_ctl_reg;
  reg         irq_en_reg;
  reg         expired_reg;
  reg  [3:0]  select_reg;
  reg  [7:0]  sys_mux_reg;
  reg  [7:0]  dejitter_reg;
  reg  [7:0]  tx_a_reg;
  reg  [7:0]  tx_b_reg;
  reg  [7:0]  line_std_reg;
  reg  [6:0]  jitter_status_reg;
  reg  [31:0] sec_count_reg;
  reg         soft_reset_reg;
  reg         gp_meta_reg;
  reg         gp_sync_reg;
  reg  [7:0]  read_byte;
  reg  [6:0]  margin;
  reg  [6:0]  fifo_size;

  wire [11:0] reg_index = paddr[13:2];
  wire        wr_fire   = psel & penable & pwrite & (state_reg == ST_ACCESS);
  wire        rd_fire   = psel & penable & ~pwrite & (state_reg == ST_ACCESS);
  wire        lane0     = pstrb[0];
  wire [7:0]  wbyte     = pwdata[7:0];
  wire        sec_tick  = (sec_count_reg == SECOND_CYCLES - 1);
  wire        mapped;
  wire [7:0]  counter_read_byte;
  wire        t1_mode   = line_std_reg[`T1GC_LS_SELECT_BIT];

  // ****************************************
  // APB handshake: one wait state
  // ****************************************
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (psel && !penable) begin
          state_next = ST_ACCESS;
        end
      end
      ST_ACCESS: begin
        state_next = ST_DONE;
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign mapped = (reg_index == `T1GC_IDX_CHIP_IDENTITY)   ||
                  (reg_index == `T1GC_IDX_SOFT_RESET)      ||
                  (reg_index == `T1GC_IDX_GP_PIN_CONTROL)  ||
                  (reg_index == `T1GC_IDX_TIMER_IRQ_EN)    ||
                  (reg_index == `T1GC_IDX_TIMER_IRQ_FLAG)  ||
                  (reg_index == `T1GC_IDX_COUNTER_SELECT)  ||
                  (reg_index == `T1GC_IDX_COUNTER_DATA)    ||
                  (reg_index == `T1GC_IDX_SYS_MUX_CONFIG)  ||
                  (reg_index == `T1GC_IDX_LINE_STANDARD)   ||
                  (reg_index == `T1GC_IDX_DEJITTER_CONFIG) ||
                  (reg_index == `T1GC_IDX_TX_PATH_CFG_A)   ||
                  (reg_index == `T1GC_IDX_TX_PATH_CFG_B)   ||
                  (reg_index == `T1GC_IDX_JITTER_STATUS);

  // ****************************************
  // Read mux
  // ****************************************
  always @* begin
    read_byte = `T1GC_RST_ZERO;
    case (reg_index)
      `T1GC_IDX_CHIP_IDENTITY:   read_byte = {PART_CODE, REV_CODE};
      `T1GC_IDX_GP_PIN_CONTROL: begin
        read_byte = gp_ctl_reg & `T1GC_MASK_GP_PIN;
        if (gp_ctl_reg[`T1GC_GP_DIR_BIT]) begin
          read_byte[`T1GC_GP_LEVEL_BIT] = gp_sync_reg;
        end
      end
      `T1GC_IDX_TIMER_IRQ_EN:    read_byte = {7'h00, irq_en_reg};
      `T1GC_IDX_TIMER_IRQ_FLAG:  read_byte = {7'h00, expired_reg};
      `T1GC_IDX_COUNTER_SELECT:  read_byte = {4'h0, select_reg};
      `T1GC_IDX_COUNTER_DATA:    read_byte = counter_read_byte;
      `T1GC_IDX_SYS_MUX_CONFIG:  read_byte = sys_mux_reg;
      `T1GC_IDX_LINE_STANDARD:   read_byte = line_std_reg;
      `T1GC_IDX_DEJITTER_CONFIG: read_byte = dejitter_reg;
      `T1GC_IDX_TX_PATH_CFG_A:   read_byte = tx_a_reg;
      `T1GC_IDX_TX_PATH_CFG_B:   read_byte = tx_b_reg;
      `T1GC_IDX_JITTER_STATUS:   read_byte = {1'b0, jitter_status_reg};
      default:                   read_byte = `T1GC_RST_ZERO;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= (state_reg == ST_ACCESS) & psel & penable;
      pslverr <= (state_reg == ST_ACCESS) & psel & penable & ~mapped;
      if (rd_fire) begin
        prdata <= {24'h00_0000, read_byte};
      end
    end
  end

  // ****************************************
  // Pin synchroniser
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gp_meta_reg <= 1'b0;
      gp_sync_reg <= 1'b0;
    end else begin
      gp_meta_reg <= gp_pin_in;
      gp_sync_reg <= gp_meta_reg;
    end
  end

  // ****************************************
  // Soft reset and line standard
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_reset_reg <= 1'b0;
      line_std_reg   <= `T1GC_RST_ZERO;
    end else begin
      soft_reset_reg <= wr_fire & (reg_index == `T1GC_IDX_SOFT_RESET);
      // Line standard survives soft reset
      if (wr_fire && lane0 && reg_index == `T1GC_IDX_LINE_STANDARD) begin
        line_std_reg <= wbyte & `T1GC_MASK_SELECT;
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gp_ctl_reg   <= `T1GC_RST_GP_PIN;
      irq_en_reg   <= 1'b0;
      select_reg   <= 4'h0;
      sys_mux_reg  <= `T1GC_RST_ZERO;
      dejitter_reg <= `T1GC_RST_ZERO;
      tx_a_reg     <= `T1GC_RST_ZERO;
      tx_b_reg     <= `T1GC_RST_TX_CFG_B;
    end else if (soft_reset_reg) begin
      gp_ctl_reg   <= `T1GC_RST_GP_PIN;
      irq_en_reg   <= 1'b0;
      select_reg   <= 4'h0;
      sys_mux_reg  <= `T1GC_RST_ZERO;
      dejitter_reg <= `T1GC_RST_ZERO;
      tx_a_reg     <= `T1GC_RST_ZERO;
      tx_b_reg     <= `T1GC_RST_TX_CFG_B;
    end else if (wr_fire && lane0) begin
      case (reg_index)
        `T1GC_IDX_GP_PIN_CONTROL:  gp_ctl_reg   <= wbyte & `T1GC_MASK_GP_PIN;
        `T1GC_IDX_TIMER_IRQ_EN:    irq_en_reg   <= wbyte[0];
        `T1GC_IDX_COUNTER_SELECT:  select_reg   <= wbyte[3:0];
        `T1GC_IDX_SYS_MUX_CONFIG:  sys_mux_reg  <= wbyte & `T1GC_MASK_SYS_MUX;
        `T1GC_IDX_DEJITTER_CONFIG: dejitter_reg <= wbyte & `T1GC_MASK_DEJITTER;
        `T1GC_IDX_TX_PATH_CFG_A:   tx_a_reg     <= wbyte & `T1GC_MASK_TX_CFG_A;
        `T1GC_IDX_TX_PATH_CFG_B:   tx_b_reg     <= wbyte & `T1GC_MASK_TX_CFG_B;
        default:                   gp_ctl_reg   <= gp_ctl_reg;
      endcase
    end
  end

  // ****************************************
  // One-second timer and expired flag
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec_count_reg <= 32'h0000_0000;
      expired_reg   <= 1'b0;
    end else if (soft_reset_reg) begin
      sec_count_reg <= 32'h0000_0000;
      expired_reg   <= 1'b0;
    end else begin
      sec_count_reg <= sec_tick ? 32'h0000_0000 : sec_count_reg + 32'h0000_0001;
      if (sec_tick) begin
        expired_reg <= 1'b1;
      end else if (wr_fire && lane0 && reg_index == `T1GC_IDX_TIMER_IRQ_FLAG
                   && wbyte[0]) begin
        expired_reg <= 1'b0;
      end
    end
  end

  // ****************************************
  // Jitter status: live or peak distance
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      jitter_status_reg <= 7'h00;
    end else if (soft_reset_reg) begin
      jitter_status_reg <= 7'h00;
    end else if (!dejitter_reg[`T1GC_DJ_PEAK_BIT]) begin
      jitter_status_reg <= tx_fifo_distance;
    end else if (tx_fifo_distance > jitter_status_reg) begin
      jitter_status_reg <= tx_fifo_distance;
    end
  end

  // ****************************************
  // Attenuator depth and limit window
  // ****************************************
  always @* begin
    case (dejitter_reg[`T1GC_DJ_DEPTH_HI:`T1GC_DJ_DEPTH_LO])
      `T1GC_DEPTH_128: begin
        margin    = `T1GC_MARGIN_128;
        fifo_size = `T1GC_SIZE_128;
      end
      `T1GC_DEPTH_64: begin
        margin    = `T1GC_MARGIN_64;
        fifo_size = `T1GC_SIZE_64;
      end
      default: begin
        margin    = `T1GC_MARGIN_32;
        fifo_size = `T1GC_SIZE_32;
      end
    endcase
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_reset_pulse        <= 1'b0;
      t1_mode_active          <= 1'b0;
      gp_pin_out              <= 1'b0;
      gp_pin_oe               <= 1'b0;
      int_n                   <= 1'b1;
      rx_system_side_muxed    <= 1'b0;
      tx_system_side_muxed    <= 1'b0;
      tx_dejitter_enable      <= 1'b0;
      tx_dejitter_bandwidth   <= 1'b0;
      tx_dejitter_depth       <= 2'b00;
      tx_dejitter_bypass      <= 1'b0;
      tx_path_power_off       <= 1'b0;
      tx_line_code_select     <= 1'b0;
      tx_driver_hiz           <= 1'b1;
      driver_fault_monitor_en <= 1'b0;
      tx_pulse_shape          <= 4'h0;
    end else begin
      soft_reset_pulse     <= soft_reset_reg;
      t1_mode_active       <= t1_mode;
      gp_pin_out           <= gp_ctl_reg[`T1GC_GP_LEVEL_BIT];
      gp_pin_oe            <= ~gp_ctl_reg[`T1GC_GP_DIR_BIT];
      int_n                <= ~(t1_mode & expired_reg & irq_en_reg);
      rx_system_side_muxed <= sys_mux_reg[`T1GC_RX_MUX_BIT];
      tx_system_side_muxed <= sys_mux_reg[`T1GC_TX_MUX_BIT];
      tx_dejitter_enable   <= t1_mode & dejitter_reg[`T1GC_DJ_ENABLE_BIT];
      tx_dejitter_bandwidth <= dejitter_reg[`T1GC_DJ_BW_BIT];
      tx_dejitter_depth    <= dejitter_reg[`T1GC_DJ_DEPTH_HI:`T1GC_DJ_DEPTH_LO];
      // Widened bandwidth: stop attenuating near either FIFO limit
      tx_dejitter_bypass   <= dejitter_reg[`T1GC_DJ_WIDEN_BIT] &
                              ((tx_fifo_distance < margin) ||
                               (tx_fifo_distance > fifo_size - margin));
      tx_path_power_off    <= tx_a_reg[`T1GC_TX_OFF_BIT];
      tx_line_code_select  <= tx_a_reg[`T1GC_TX_CODE_BIT];
      tx_driver_hiz        <= tx_b_reg[`T1GC_TX_HZ_BIT] | tx_a_reg[`T1GC_TX_OFF_BIT];
      driver_fault_monitor_en <= tx_b_reg[`T1GC_TX_FAULT_MON_BIT];
      tx_pulse_shape       <= tx_b_reg[`T1GC_TX_SHAPE_HI:0];
    end
  end

  // ****************************************
  // Counter window
  // ****************************************
  t1gc_counter_window u_window (
    .pclk              (pclk),
    .presetn           (presetn),
    .soft_clear        (soft_reset_reg),
    .counter_bytes     (counter_bytes),
    .select            (select_reg),
    .counter_read_byte (counter_read_byte)
  );

endmodule

// [sim/t1gc_regs_sva.sv]
// Port assertions for the T1/J1 global control register bank
`timescale 1ns/100ps

module t1gc_regs_sva (
  // APB
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [13:0] paddr,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  // Watched outputs
  input logic        int_n,
  input logic        soft_reset_pulse,
  input logic        t1_mode_active,
  input logic        gp_pin_oe,
  input logic        tx_dejitter_enable,
  input logic        tx_line_code_select,
  input logic        tx_path_power_off,
  input logic        tx_driver_hiz
);
  logic [11:0] idx;
  logic        mapped;
  assign idx    = paddr[13:2];
  assign mapped = idx inside {12'h001, 12'h004, 12'h006, 12'h00a, 12'h00b, 12'h00e,
                              12'h00f, 12'h010, 12'h020, 12'h021, 12'h022, 12'h023, 12'h038};
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ****************************************
  // Sequences
  // ****************************************
  sequence s_done;
    psel && penable && pready;
  endsequence
  sequence s_reset_write;
    psel && penable && pready && pwrite && idx == 12'h004;
  endsequence
  sequence s_defaults;
    tx_driver_hiz && !gp_pin_oe && !tx_dejitter_enable && !tx_line_code_select;
  endsequence
  // ****************************************
  // Assertions
  // ****************************************
  a_one_wait_state:
    assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("ready not one cycle after access start");
  a_ready_pulse:
    assert property (pready |=> !pready)
    else $error("ready held beyond one cycle");
  a_err_unmapped:
    assert property (s_done |-> pslverr == !mapped)
    else $error("error response does not match address map");
  a_upper_zero:
    assert property (s_done |-> prdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  a_reset_pulse:
    assert property (s_reset_write |-> ##[1:3] soft_reset_pulse)
    else $error("reset register write gave no reset pulse");
  a_soft_defaults:
    assert property (soft_reset_pulse |-> ##[1:3] s_defaults)
    else $error("outputs not at defaults after soft reset");
  a_mode_kept:
    assert property (soft_reset_pulse |=> $stable(t1_mode_active) [*3])
    else $error("line standard changed by soft reset");
  a_int_mode:
    assert property (!int_n |-> t1_mode_active)
    else $error("interrupt outside T1 mode");
  a_off_hiz:
    assert property (tx_path_power_off |-> tx_driver_hiz)
    else $error("driver not floated with path off");
endmodule

// [sim/t1gc_regs_tb_top.sv]
// Self-checking testbench for the T1/J1 global control register bank
`timescale 1ns/100ps

module t1gc_regs_tb_top;
  localparam int LIMIT = 20000;
  localparam logic [31:0] ID_EXP = 32'h62;
  // ****************************************
  // Signals
  // ****************************************
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb, tx_pulse_shape;
  logic        gp_pin_in, gp_pin_out, gp_pin_oe, int_n, soft_reset_pulse, t1_mode_active;
  logic [6:0]  tx_fifo_distance;
  logic [95:0] counter_bytes;
  logic        rx_system_side_muxed, tx_system_side_muxed, tx_dejitter_enable;
  logic        tx_dejitter_bandwidth, tx_dejitter_bypass, tx_path_power_off;
  logic        tx_line_code_select, tx_driver_hiz, driver_fault_monitor_en;
  logic [1:0]  tx_dejitter_depth;
  int          mismatches, checked, cycles, pulses, p0;

  // Part and revision codes are arbitrary
  t1gc_regs #(.SECOND_CYCLES(50), .PART_CODE(4'h6), .REV_CODE(4'h2)) dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gp_pin_in(gp_pin_in), .gp_pin_out(gp_pin_out), .gp_pin_oe(gp_pin_oe),
    .int_n(int_n), .tx_fifo_distance(tx_fifo_distance), .counter_bytes(counter_bytes),
    .soft_reset_pulse(soft_reset_pulse), .t1_mode_active(t1_mode_active),
    .rx_system_side_muxed(rx_system_side_muxed), .tx_system_side_muxed(tx_system_side_muxed),
    .tx_dejitter_enable(tx_dejitter_enable), .tx_dejitter_bandwidth(tx_dejitter_bandwidth),
    .tx_dejitter_depth(tx_dejitter_depth), .tx_dejitter_bypass(tx_dejitter_bypass),
    .tx_path_power_off(tx_path_power_off), .tx_line_code_select(tx_line_code_select),
    .tx_driver_hiz(tx_driver_hiz), .driver_fault_monitor_en(driver_fault_monitor_en),
    .tx_pulse_shape(tx_pulse_shape));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (soft_reset_pulse === 1'b1) begin
      pulses <= pulses + 1;
    end
    if (cycles == LIMIT) begin
      mismatches++;
      results;
    end
  end
  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic results;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {idx, 2'b00};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("pready", 1, pready);
  endtask

  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask

  task automatic rdc(input string name, input logic [11:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(name, exp, rd);
  endtask

  task automatic settle;
    repeat (2) @(posedge pclk);
  endtask

  task automatic bp(input logic [6:0] d, input logic e);
    @(posedge pclk);
    tx_fifo_distance <= d;
    settle;
    chk("bypass", e, tx_dejitter_bypass);
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset_values;
    chk("oe", 0, gp_pin_oe);
    chk("hiz", 1, tx_driver_hiz);
    rdc("id", 12'h001, ID_EXP);
    wr(12'h001, 8'hff);
    rdc("id", 12'h001, ID_EXP);
    rdc("gp", 12'h006, 8'h01);
    rdc("txb", 12'h023, 8'h10);
    rdc("dj", 12'h021, 8'h00);
  endtask

  task automatic t_map;
    apb(1'b0, 12'h005, 8'h00);
    chk("err", 1, err);
    chk("rd", 0, rd);
    wr(12'h010, 8'hff);
    rdc("mux", 12'h010, 8'h09);
    wr(12'h010, 8'h08);
    settle;
    chk("rxm", 1, rx_system_side_muxed);
    chk("txm", 0, tx_system_side_muxed);
    wr(12'h010, 8'h01);
    settle;
    chk("rxm", 0, rx_system_side_muxed);
    chk("txm", 1, tx_system_side_muxed);
  endtask

  task automatic t_gpio;
    wr(12'h006, 8'h04);
    settle;
    chk("oe", 1, gp_pin_oe);
    chk("pin", 1, gp_pin_out);
    rdc("gp", 12'h006, 8'h04);
    wr(12'h006, 8'h00);
    settle;
    chk("pin", 0, gp_pin_out);
    gp_pin_in <= 1'b1;
    wr(12'h006, 8'h01);
    rdc("gp", 12'h006, 8'h05);
    gp_pin_in <= 1'b0;
    wr(12'h006, 8'h05);
    rdc("gp", 12'h006, 8'h01);
  endtask

  task automatic t_timer;
    int n;
    n = 0;
    wr(12'h020, 8'h01);
    wr(12'h004, 8'h00);
    repeat (4) @(posedge pclk);
    wr(12'h00a, 8'h01);
    while (int_n !== 1'b0 && n < 60) begin
      @(posedge pclk);
      n++;
    end
    chk("int", 0, int_n);
    rdc("flag", 12'h00b, 8'h01);
    wr(12'h00b, 8'h01);
    settle;
    chk("int", 1, int_n);
    wr(12'h00a, 8'h00);
    repeat (60) @(posedge pclk);
    chk("int", 1, int_n);
    rdc("flag", 12'h00b, 8'h01);
    wr(12'h00a, 8'h01);
    wr(12'h020, 8'h00);
    settle;
    chk("int", 1, int_n);
    wr(12'h020, 8'h01);
    wr(12'h00a, 8'h00);
    wr(12'h004, 8'h00);
  endtask

  task automatic t_counter;
    for (int k = 0; k < 12; k++) begin
      wr(12'h00e, 8'(k));
      rdc("cnt", 12'h00f, 32'ha0 + k);
    end
    wr(12'h00e, 8'hfc);
    rdc("sel", 12'h00e, 8'h0c);
    rdc("cnt", 12'h00f, 8'h00);
  endtask

  task automatic t_dejitter;
    wr(12'h021, 8'h0f);
    settle;
    chk("dje", 1, tx_dejitter_enable);
    chk("djd", 3, tx_dejitter_depth);
    chk("djb", 1, tx_dejitter_bandwidth);
    wr(12'h020, 8'h00);
    settle;
    chk("dje", 0, tx_dejitter_enable);
    wr(12'h020, 8'h01);
    wr(12'h004, 8'h00);
    bp(7'h01, 1'b0);
    tx_fifo_distance <= 7'h15;
    rdc("jit", 12'h038, 8'h15);
    wr(12'h021, 8'h20);
    tx_fifo_distance <= 7'h30;
    rdc("jit", 12'h038, 8'h30);
    tx_fifo_distance <= 7'h10;
    rdc("jit", 12'h038, 8'h30);
    chk("dje", 0, tx_dejitter_enable);
    wr(12'h021, 8'h14);
    bp(7'h01, 1'b1);
    bp(7'h10, 1'b0);
    bp(7'h1f, 1'b1);
    wr(12'h021, 8'h12);
    bp(7'h02, 1'b1);
    bp(7'h03, 1'b0);
    bp(7'h3e, 1'b1);
    wr(12'h021, 8'h10);
    bp(7'h04, 1'b0);
    bp(7'h7c, 1'b1);
  endtask

  task automatic t_tx;
    wr(12'h022, 8'h11);
    settle;
    chk("off", 1, tx_path_power_off);
    chk("code", 1, tx_line_code_select);
    chk("hiz", 1, tx_driver_hiz);
    wr(12'h022, 8'h00);
    wr(12'h023, 8'hff);
    rdc("txb", 12'h023, 8'h3f);
    chk("code", 0, tx_line_code_select);
    chk("hiz", 1, tx_driver_hiz);
    wr(12'h023, 8'h2a);
    settle;
    chk("hiz", 0, tx_driver_hiz);
    chk("fmon", 1, driver_fault_monitor_en);
    chk("shape", 4'ha, tx_pulse_shape);
  endtask

  task automatic t_soft_reset;
    wr(12'h021, 8'h0f);
    wr(12'h022, 8'h01);
    p0 = pulses;
    wr(12'h004, 8'h5a);
    repeat (4) @(posedge pclk);
    chk("pulses", 1, pulses - p0);
    rdc("txb", 12'h023, 8'h10);
    rdc("dj", 12'h021, 8'h00);
    rdc("txa", 12'h022, 8'h00);
    rdc("gp", 12'h006, 8'h01);
    rdc("mux", 12'h010, 8'h00);
    rdc("mode", 12'h020, 8'h01);
    chk("t1", 1, t1_mode_active);
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {psel, penable, pwrite, presetn, gp_pin_in} = 5'b00000;
    paddr = 14'h0000;
    pwdata = 32'h0;
    pstrb = 4'hf;
    tx_fifo_distance = 7'h00;
    {mismatches, checked} = {2{32'sd0}};
    for (int k = 0; k < 12; k++) begin
      counter_bytes[8*k +: 8] = 8'ha0 + 8'(k);
    end
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_values;
    t_map;
    t_gpio;
    t_timer;
    t_counter;
    t_dejitter;
    t_tx;
    t_soft_reset;
    results;
  end
endmodule

bind t1gc_regs t1gc_regs_sva u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .int_n(int_n),
  .soft_reset_pulse(soft_reset_pulse), .t1_mode_active(t1_mode_active), .gp_pin_oe(gp_pin_oe),
  .tx_dejitter_enable(tx_dejitter_enable), .tx_line_code_select(tx_line_code_select),
  .tx_path_power_off(tx_path_power_off), .tx_driver_hiz(tx_driver_hiz));
